// ---- pas_aux_page.v ----
// auxiliary control/status word and page select with paged window
`timescale 1ns/100ps
`include "pas_defs.vh"
module pas_aux_page #(
  parameter TICKS_PER_UNIT = `PAS_TICKS_PER_UNIT,
  parameter [14:0] EXT1_DEFINED = 15'h6074,
  parameter [14:0] EXT2_DEFINED = 15'h7FFF,
  parameter [14:0] GP_DEFINED = 15'h7FFF
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire soft_rst,
  input wire sticky_reset_control,
  input wire [4:0] mgmt_addr,
  input wire [15:0] mgmt_wdata,
  input wire mgmt_wr,
  input wire mgmt_rd,
  output wire [15:0] mgmt_rdata,
  input wire negotiation_complete,
  input wire negotiation_enable_control,
  input wire descrambler_lock_flag,
  input wire pair_swap_correction_enable,
  input wire crossover_absent,
  input wire pairs_cd_swapped,
  input wire [3:0] pair_polarity_inverted,
  input wire resolved_duplex_in,
  input wire [1:0] resolved_speed_in,
  input wire link_status,
  input wire energy_detect,
  output reg [4:0] page_select,
  output reg link_loss_power_save_enable,
  output wire [1:0] link_loss_timer_code,
  output wire low_power_state,
  output reg link_state_change_event
);

  // window slots for pages held in the backing memory
  localparam SLOT_EXT1 = 2'h0;
  localparam SLOT_EXT2 = 2'h1;
  localparam SLOT_GP = 2'h2;
  localparam SLOT_NONE = 2'h3;

  // writable fields of the auxiliary word
  reg link_loss_timer_high;
  reg link_loss_timer_low;

  // sampled status sources
  reg no_crossover_flag;
  reg pairs_cd_swapped_flag;
  reg pair_a_polarity_flag;
  reg pair_b_polarity_flag;
  reg pair_c_polarity_flag;
  reg pair_d_polarity_flag;
  reg resolved_duplex;
  reg [1:0] resolved_speed;

  // edge detection for the link change event
  reg link_prev;
  reg energy_prev;

  // combinational decode results
  wire negotiation_done_mirror;
  wire negotiation_disabled_flag;
  wire xover_valid;
  wire neg_valid;
  wire gig_valid;
  wire in_window;
  wire [3:0] win_offset;
  wire [1:0] cur_slot;
  wire win_defined;
  wire [5:0] mem_addr;
  wire mem_wr;
  wire mem_rd_sel;
  reg [15:0] aux_word;
  reg [15:0] local_rdata;
  wire aux_wr;
  wire page_wr;
  wire aux_rd_sel;
  wire link_toggle;
  wire energy_rise;
  wire [3:0] pair_pol_flags;
  wire [3:0] pair_pol_valid;
  wire [3:0] pair_pol_shown;

  // next values of the control registers and the event pulse
  reg next_link_loss_timer_high;
  reg next_link_loss_timer_low;
  reg next_link_loss_power_save_enable;
  reg [4:0] next_page_select;
  reg next_link_state_change_event;

  // map a page code onto a backing memory slot
  function [1:0] page_slot;
    input [4:0] page;
    begin
      if (page == `PAS_PAGE_EXT1) begin
        page_slot = SLOT_EXT1;
      end else if (page == `PAS_PAGE_EXT2) begin
        page_slot = SLOT_EXT2;
      end else if (page == `PAS_PAGE_GP) begin
        page_slot = SLOT_GP;
      end else begin
        page_slot = SLOT_NONE;
      end
    end
  endfunction

  // true when a window offset exists on the given slot
  function slot_defines;
    input [1:0] slot;
    input [3:0] off;
    begin
      if (off == 4'hF) begin
        slot_defines = 1'b0;
      end else if (slot == SLOT_EXT1) begin
        slot_defines = EXT1_DEFINED[off];
      end else if (slot == SLOT_EXT2) begin
        slot_defines = EXT2_DEFINED[off];
      end else if (slot == SLOT_GP) begin
        slot_defines = GP_DEFINED[off];
      end else begin
        slot_defines = 1'b0;
      end
    end
  endfunction

  // true when the aux word is mapped at this address and page
  function aux_mapped;
    input [4:0] addr;
    input [4:0] page;
    begin
      if (addr == `PAS_ADDR_AUX && page == `PAS_PAGE_STD) begin
        aux_mapped = 1'b1;
      end else begin
        aux_mapped = 1'b0;
      end
    end
  endfunction

  // mirror and negation straight from their sources
  assign negotiation_done_mirror = negotiation_complete;
  assign negotiation_disabled_flag = ~negotiation_enable_control;

  // validity windows of the reported pair conditions
  assign xover_valid = descrambler_lock_flag &
                       pair_swap_correction_enable;
  assign neg_valid = negotiation_complete;
  assign gig_valid = negotiation_complete &
                     (resolved_speed == `PAS_SPEED_GIG);

  // paged window decode, driven by the address and the current page
  assign in_window = (mgmt_addr >= `PAS_WIN_FIRST) &&
                     (mgmt_addr <= `PAS_WIN_LAST);
  assign win_offset = mgmt_addr[3:0];
  assign cur_slot = page_slot(page_select);
  assign win_defined = in_window &&
                       slot_defines(cur_slot, win_offset);
  assign mem_addr = {cur_slot, win_offset};
  assign mem_wr = mgmt_wr & win_defined;
  assign mem_rd_sel = win_defined;

  // register strobes, decoded once for every field they load
  assign aux_wr = mgmt_wr & aux_mapped(mgmt_addr, page_select);
  assign page_wr = mgmt_wr & (mgmt_addr == `PAS_ADDR_PAGE);
  assign aux_rd_sel = aux_mapped(mgmt_addr, page_select);

  // per pair polarity report, shown only while it is valid
  assign pair_pol_flags = {pair_d_polarity_flag, pair_c_polarity_flag,
                           pair_b_polarity_flag, pair_a_polarity_flag};
  assign pair_pol_valid = {gig_valid, gig_valid, neg_valid, neg_valid};
  genvar pp;
  generate
    for (pp = 0; pp < 4; pp = pp + 1) begin : pol_show
      assign pair_pol_shown[pp] = pair_pol_flags[pp] &
                                  pair_pol_valid[pp];
    end
  endgenerate

  assign link_loss_timer_code = {link_loss_timer_high,
                                 link_loss_timer_low};

  // sample the status inputs; reset values equal the sources' defaults
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      no_crossover_flag <= 1'b0;
      pairs_cd_swapped_flag <= 1'b0;
      pair_a_polarity_flag <= 1'b0;
      pair_b_polarity_flag <= 1'b0;
      pair_c_polarity_flag <= 1'b0;
      pair_d_polarity_flag <= 1'b0;
      resolved_duplex <= 1'b0;
      resolved_speed <= 2'h0;
    end else begin
      no_crossover_flag <= crossover_absent;
      pairs_cd_swapped_flag <= pairs_cd_swapped;
      // one means not inverted on the pair
      pair_a_polarity_flag <= ~pair_polarity_inverted[0];
      pair_b_polarity_flag <= ~pair_polarity_inverted[1];
      pair_c_polarity_flag <= ~pair_polarity_inverted[2];
      pair_d_polarity_flag <= ~pair_polarity_inverted[3];
      resolved_duplex <= resolved_duplex_in;
      resolved_speed <= resolved_speed_in;
    end
  end

  // next timer bits: soft reset restores the default code
  always @* begin
    next_link_loss_timer_high = link_loss_timer_high;
    next_link_loss_timer_low = link_loss_timer_low;
    if (soft_rst) begin
      next_link_loss_timer_high = `PAS_RST_TMR_HI;
      next_link_loss_timer_low = `PAS_RST_TMR_LO;
    end else if (aux_wr) begin
      next_link_loss_timer_high = mgmt_wdata[`PAS_BIT_TMR_HI];
      next_link_loss_timer_low = mgmt_wdata[`PAS_BIT_TMR_LO];
    end
  end

  // next sticky enable: soft reset clears it only when allowed
  always @* begin
    next_link_loss_power_save_enable = link_loss_power_save_enable;
    if (soft_rst) begin
      if (sticky_reset_control) begin
        next_link_loss_power_save_enable = `PAS_RST_PS_ENA;
      end
    end else if (aux_wr) begin
      next_link_loss_power_save_enable = mgmt_wdata[`PAS_BIT_PS_ENA];
    end
  end

  // next page: any five-bit code is kept, bits above are dropped
  always @* begin
    next_page_select = page_select;
    if (soft_rst) begin
      next_page_select = `PAS_RST_PAGE;
    end else if (page_wr) begin
      next_page_select = mgmt_wdata[4:0];
    end
  end

  // control registers; system reset restores every default
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      link_loss_timer_high <= `PAS_RST_TMR_HI;
      link_loss_timer_low <= `PAS_RST_TMR_LO;
      link_loss_power_save_enable <= `PAS_RST_PS_ENA;
      page_select <= `PAS_RST_PAGE;
    end else begin
      link_loss_timer_high <= next_link_loss_timer_high;
      link_loss_timer_low <= next_link_loss_timer_low;
      link_loss_power_save_enable <= next_link_loss_power_save_enable;
      page_select <= next_page_select;
    end
  end

  // assemble the auxiliary word; invalid pair fields read default
  always @* begin
    aux_word = 16'h0000;
    aux_word[`PAS_BIT_NEG_DONE] = negotiation_done_mirror;
    aux_word[`PAS_BIT_NEG_OFF] = negotiation_disabled_flag;
    aux_word[`PAS_BIT_NO_XOVER] = no_crossover_flag &
                                  xover_valid;
    aux_word[`PAS_BIT_CD_SWAP] = pairs_cd_swapped_flag &
                                 neg_valid;
    aux_word[`PAS_BIT_POL_A] = pair_pol_shown[0];
    aux_word[`PAS_BIT_POL_B] = pair_pol_shown[1];
    aux_word[`PAS_BIT_POL_C] = pair_pol_shown[2];
    aux_word[`PAS_BIT_POL_D] = pair_pol_shown[3];
    aux_word[`PAS_BIT_TMR_HI] = link_loss_timer_high;
    aux_word[`PAS_BIT_PS_ENA] = link_loss_power_save_enable;
    aux_word[`PAS_BIT_DUPLEX] = resolved_duplex;
    aux_word[`PAS_BIT_SPEED_HI] = resolved_speed[1];
    aux_word[`PAS_BIT_SPEED_LO] = resolved_speed[0];
    aux_word[`PAS_BIT_TMR_LO] = link_loss_timer_low;
  end

  // read decode for words not held in the backing memory
  always @* begin
    local_rdata = 16'h0000;
    if (mgmt_addr == `PAS_ADDR_PAGE) begin
      local_rdata = {11'h000, page_select};
    end else if (aux_rd_sel) begin
      local_rdata = aux_word;
    end else begin
      local_rdata = 16'h0000;
    end
  end

  // backing words of the extended pages and the read data register
  pas_page_mem #(
    .ADDR_W(6),
    .DATA_W(16),
    .DEPTH(48)
  ) u_mem (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wr_en(mem_wr),
    .wr_addr(mem_addr),
    .wr_data(mgmt_wdata),
    .rd_en(mgmt_rd),
    .rd_from_mem(mem_rd_sel),
    .rd_addr(mem_addr),
    .rd_bypass(local_rdata),
    .rd_data(mgmt_rdata)
  );

  // link-loss timeout into low power
  pas_link_timer #(
    .TICKS_PER_UNIT(TICKS_PER_UNIT),
    .PRE_W(24)
  ) u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(link_loss_power_save_enable),
    .timeout_code(link_loss_timer_code),
    .link_status(link_status),
    .energy_detect(energy_detect),
    .low_power_state(low_power_state)
  );

  // edges of the link level and of energy on the media
  assign link_toggle = link_status ^ link_prev;
  assign energy_rise = energy_detect & ~energy_prev;

  // link change pulse; energy counts only while power save is on
  always @* begin
    next_link_state_change_event = link_toggle;
    if (link_loss_power_save_enable && energy_rise) begin
      next_link_state_change_event = 1'b1;
    end
  end

  // event register and edge history
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      link_prev <= 1'b0;
      energy_prev <= 1'b0;
      link_state_change_event <= 1'b0;
    end else begin
      link_prev <= link_status;
      energy_prev <= energy_detect;
      link_state_change_event <= next_link_state_change_event;
    end
  end

endmodule

// ---- pas_aux_page_checker.sv ----
// assertions for the aux status and page select block
`timescale 1ns/100ps
module pas_aux_page_checker (
  input wire clk_sys,
  input wire sys_rst,
  input wire soft_rst,
  input wire [4:0] mgmt_addr,
  input wire [15:0] mgmt_wdata,
  input wire mgmt_wr,
  input wire mgmt_rd,
  input wire [15:0] mgmt_rdata,
  input wire negotiation_complete,
  input wire negotiation_enable_control,
  input wire [1:0] resolved_speed_in,
  input wire link_status,
  input wire energy_detect,
  input wire [4:0] page_select,
  input wire link_loss_power_save_enable,
  input wire [1:0] link_loss_timer_code,
  input wire low_power_state,
  input wire link_state_change_event
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // aux word read while page 0 is mapped
  sequence aux_rd;
    mgmt_rd && mgmt_addr == 5'h1C && page_select == 5'h00;
  endsequence
  // page register write without a soft reset
  sequence pg_wr;
    mgmt_wr && mgmt_addr == 5'h1F && !soft_rst;
  endsequence
  a_page_write: assert property (
    pg_wr |=> page_select == $past(mgmt_wdata[4:0]))
    else $error("page write not taken");
  a_done_mirror: assert property (
    aux_rd |=> mgmt_rdata[15] == $past(negotiation_complete))
    else $error("done mirror wrong");
  a_neg_off: assert property (
    aux_rd |=> mgmt_rdata[14] != $past(negotiation_enable_control))
    else $error("negotiation off flag wrong");
  a_speed_field: assert property (
    aux_rd |=> mgmt_rdata[4:3] == $past(resolved_speed_in, 2))
    else $error("speed field wrong");
  a_ctrl_bits: assert property (
    aux_rd |=> {mgmt_rdata[7], mgmt_rdata[2]} == $past(link_loss_timer_code)
      && mgmt_rdata[6] == $past(link_loss_power_save_enable))
    else $error("control bits wrong");
  a_soft_defaults: assert property (
    soft_rst |=> link_loss_timer_code == 2'h1 && page_select == 5'h00)
    else $error("soft reset defaults wrong");
  a_unmapped_zero: assert property (
    mgmt_rd && mgmt_addr < 5'h10 |=> mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_link_event: assert property (
    !$past(sys_rst) && $changed(link_status) |=> link_state_change_event)
    else $error("link event missing");
  a_lp_exit: assert property (
    low_power_state && (!link_loss_power_save_enable || link_status ||
      energy_detect) |=> !low_power_state)
    else $error("low power not left");
endmodule

bind pas_aux_page pas_aux_page_checker chk_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst),
  .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr),
  .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
  .negotiation_complete(negotiation_complete),
  .negotiation_enable_control(negotiation_enable_control),
  .resolved_speed_in(resolved_speed_in), .link_status(link_status),
  .energy_detect(energy_detect), .page_select(page_select),
  .link_loss_power_save_enable(link_loss_power_save_enable),
  .link_loss_timer_code(link_loss_timer_code),
  .low_power_state(low_power_state),
  .link_state_change_event(link_state_change_event)
);

// ---- pas_defs.vh ----
// constants for the auxiliary status and page select register block
//
// Operation
// - bit 15 mirrors negotiation complete flag
// - bit 14 set while negotiation is disabled
// - bit 13 no crossover, valid after lock with pair swap correction enabled
// - bit 12 pairs c/d swapped, valid after negotiation
// - bits 11:10 pair a/b polarity, 1 not inverted
// - bits 9:8 pair c/d polarity, gigabit only
// - bits 7,2 link-loss timeout, 1 to 4 s
// - bit 6 power-save enable, sticky field
// - bit 5 resolved duplex, 1 full
// - bits 4:3 resolved speed code
// - page field selects window 0x10 to 0x1E
// - page change replaces whole window
// - mirrors reset like their source fields
// - energy detect raises link change event while power save is on
`ifndef PAS_DEFS_VH
`define PAS_DEFS_VH

// management bus widths and addresses
`define PAS_ADDR_W 5
`define PAS_DATA_W 16
`define PAS_ADDR_AUX 5'h1C
`define PAS_ADDR_PAGE 5'h1F
`define PAS_WIN_FIRST 5'h10
`define PAS_WIN_LAST 5'h1E

// auxiliary register fields
`define PAS_BIT_NEG_DONE 15
`define PAS_BIT_NEG_OFF 14
`define PAS_BIT_NO_XOVER 13
`define PAS_BIT_CD_SWAP 12
`define PAS_BIT_POL_A 11
`define PAS_BIT_POL_B 10
`define PAS_BIT_POL_C 9
`define PAS_BIT_POL_D 8
`define PAS_BIT_TMR_HI 7
`define PAS_BIT_PS_ENA 6
`define PAS_BIT_DUPLEX 5
`define PAS_BIT_SPEED_HI 4
`define PAS_BIT_SPEED_LO 3
`define PAS_BIT_TMR_LO 2

// reset values
`define PAS_RST_TMR_HI 1'h0
`define PAS_RST_TMR_LO 1'h1
`define PAS_RST_PS_ENA 1'h0
`define PAS_RST_PAGE 5'h00

// page codes and the gigabit speed code
`define PAS_PAGE_STD 5'h00
`define PAS_PAGE_EXT1 5'h01
`define PAS_PAGE_EXT2 5'h02
`define PAS_PAGE_GP 5'h10
`define PAS_SPEED_GIG 2'h2

// timing
`define PAS_TIMER_UNIT_MS 1000
`define PAS_CLK_PERIOD_NS 100
`define PAS_TICKS_PER_UNIT ((`PAS_TIMER_UNIT_MS * 1000000) / `PAS_CLK_PERIOD_NS)

`endif

// ---- pas_link_timer.v ----
// link-loss timer that moves the port into low power
`timescale 1ns/100ps
module pas_link_timer #(
  parameter TICKS_PER_UNIT = 10000000,
  parameter PRE_W = 24
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire enable,
  input wire [1:0] timeout_code,
  input wire link_status,
  input wire energy_detect,
  output reg low_power_state
);

  reg [PRE_W-1:0] prescale;
  reg [2:0] units;
  wire unit_tick;
  wire counting;

  assign unit_tick = (prescale == TICKS_PER_UNIT[PRE_W-1:0] - 1'b1);
  assign counting = enable & ~link_status & ~low_power_state;

  // count whole units while the link is lost
  always @(posedge clk_sys) begin
    if (sys_rst || !counting) begin
      prescale <= {PRE_W{1'b0}};
      units <= 3'h0;
    end else if (unit_tick) begin
      prescale <= {PRE_W{1'b0}};
      units <= units + 3'h1;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // enter low power after code+1 units, leave on energy or link
  always @(posedge clk_sys) begin
    if (sys_rst || !enable || link_status) begin
      low_power_state <= 1'b0;
    end else if (low_power_state && energy_detect) begin
      low_power_state <= 1'b0;
    end else if (counting && unit_tick &&
                 units == {1'b0, timeout_code}) begin
      low_power_state <= 1'b1;
    end
  end

endmodule

// ---- pas_page_mem.v ----
// backing words for the extended pages with a registered read port
`timescale 1ns/100ps
module pas_page_mem #(
  parameter ADDR_W = 6,
  parameter DATA_W = 16,
  parameter DEPTH = 48
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [DATA_W-1:0] wr_data,
  input wire rd_en,
  input wire rd_from_mem,
  input wire [ADDR_W-1:0] rd_addr,
  input wire [DATA_W-1:0] rd_bypass,
  output reg [DATA_W-1:0] rd_data
);

  reg [DATA_W-1:0] mem [0:DEPTH-1];

  // storage write
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data register, updated only on a read strobe
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data <= {DATA_W{1'b0}};
    end else if (rd_en) begin
      rd_data <= rd_from_mem ? mem[rd_addr] : rd_bypass;
    end
  end

endmodule

// ---- pas_sw_model.sv ----
// management master model issuing register cycles
`timescale 1ns/100ps
module pas_sw_model (
  input wire clk_sys,
  output reg [4:0] mgmt_addr = 5'h00,
  output reg [15:0] mgmt_wdata = 16'h0000,
  output reg mgmt_wr = 1'h0,
  output reg mgmt_rd = 1'h0
);
  // one write cycle, data scrambled once released
  task wr_reg(input [4:0] a, input [15:0] d);
    begin
      @(posedge clk_sys);
      mgmt_addr <= a;
      mgmt_wdata <= d;
      mgmt_wr <= 1'h1;
      @(posedge clk_sys);
      mgmt_wr <= 1'h0;
      mgmt_wdata <= ~d;
    end
  endtask
  // one read cycle
  task rd_reg(input [4:0] a);
    begin
      @(posedge clk_sys);
      mgmt_addr <= a;
      mgmt_rd <= 1'h1;
      @(posedge clk_sys);
      mgmt_rd <= 1'h0;
      mgmt_addr <= ~a;
    end
  endtask
  // map a page into the window
  task set_page(input [4:0] p);
    wr_reg(5'h1F, {11'h000, p});
  endtask
endmodule

// ---- test_pas_aux_page.sv ----
// self-checking bench for the aux status and page select block
`timescale 1ns/100ps
module test_pas_aux_page;
  logic clk_sys = 1'h0, sys_rst = 1'h1, soft_rst = 1'h0;
  logic sticky_reset_control = 1'h0, negotiation_complete = 1'h0;
  logic negotiation_enable_control = 1'h1, descrambler_lock_flag = 1'h0;
  logic pair_swap_correction_enable = 1'h0, crossover_absent = 1'h0;
  logic pairs_cd_swapped = 1'h0, resolved_duplex_in = 1'h0;
  logic [3:0] pair_polarity_inverted = 4'h0;
  logic [1:0] resolved_speed_in = 2'h0;
  logic link_status = 1'h0, energy_detect = 1'h0, rd_d = 1'h0;
  wire [4:0] mgmt_addr, page_select;
  wire [15:0] mgmt_wdata, mgmt_rdata;
  wire mgmt_wr, mgmt_rd, link_loss_power_save_enable, low_power_state;
  wire link_state_change_event;
  wire [1:0] link_loss_timer_code;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [4:0] pg [3] = '{5'h01, 5'h02, 5'h10};
  integer errors = 0, comparisons = 0, cyc = 0, seed = 97, i, n;

  pas_aux_page #(.TICKS_PER_UNIT(10)) pas_aux_page_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst),
    .sticky_reset_control(sticky_reset_control),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
    .negotiation_complete(negotiation_complete),
    .negotiation_enable_control(negotiation_enable_control),
    .descrambler_lock_flag(descrambler_lock_flag),
    .pair_swap_correction_enable(pair_swap_correction_enable),
    .crossover_absent(crossover_absent),
    .pairs_cd_swapped(pairs_cd_swapped),
    .pair_polarity_inverted(pair_polarity_inverted),
    .resolved_duplex_in(resolved_duplex_in),
    .resolved_speed_in(resolved_speed_in),
    .link_status(link_status), .energy_detect(energy_detect),
    .page_select(page_select),
    .link_loss_power_save_enable(link_loss_power_save_enable),
    .link_loss_timer_code(link_loss_timer_code),
    .low_power_state(low_power_state),
    .link_state_change_event(link_state_change_event)
  );
  pas_sw_model pas_sw_model_i (
    .clk_sys(clk_sys), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // expected aux word from current status and control shadow
  function [15:0] aux_exp(input [1:0] tc, input en);
    logic g, k;
    begin
      g = negotiation_complete;
      k = g & (resolved_speed_in == 2'h2);
      aux_exp = {g, ~negotiation_enable_control, crossover_absent &
        descrambler_lock_flag & pair_swap_correction_enable,
        pairs_cd_swapped & g, ~pair_polarity_inverted[0] & g,
        ~pair_polarity_inverted[1] & g, ~pair_polarity_inverted[2] & k,
        ~pair_polarity_inverted[3] & k, tc[1], en, resolved_duplex_in,
        resolved_speed_in, tc[0], 2'h0};
    end
  endfunction

  task stop_test;
    begin
      if (errors == 0 && comparisons > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask

  task chk(input string s, input logic x, input logic y);
    begin
      comparisons = comparisons + 1;
      if (y !== x) begin
        errors = errors + 1;
        $display("unexpected %s exp %b got %b", s, x, y);
      end
    end
  endtask

  // note the expected word, then issue the read
  task rd(input [4:0] a, input [15:0] x);
    begin
      exp_q.push_back(x);
      pas_sw_model_i.rd_reg(a);
    end
  endtask

  task soft_pulse(input s);
    begin
      @(posedge clk_sys);
      sticky_reset_control <= s;
      soft_rst <= 1'h1;
      @(posedge clk_sys);
      soft_rst <= 1'h0;
    end
  endtask

  // read data watcher, oldest note first
  always @(posedge clk_sys) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      comparisons = comparisons + 1;
      if (mgmt_rdata !== e) begin
        errors = errors + 1;
        $display("unexpected mgmt_rdata exp %h got %h", e, mgmt_rdata);
      end
    end
    rd_d <= mgmt_rd;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      stop_test;
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(5'h1C, aux_exp(2'h1, 1'h0));
    rd(5'h1F, 16'h0000);
    for (i = 0; i < 12; i = i + 1) begin
      @(posedge clk_sys);
      {negotiation_complete, negotiation_enable_control,
        descrambler_lock_flag, pair_swap_correction_enable,
        crossover_absent, pairs_cd_swapped, pair_polarity_inverted,
        resolved_duplex_in, resolved_speed_in} <= 13'($random(seed));
      @(negedge clk_sys);
      rd(5'h1C, aux_exp(2'h1, 1'h0));
    end
    pas_sw_model_i.wr_reg(5'h1C, 16'hFFFF);
    rd(5'h1C, aux_exp(2'h3, 1'h1));
    soft_pulse(1'h0);
    rd(5'h1C, aux_exp(2'h1, 1'h1));
    soft_pulse(1'h1);
    rd(5'h1C, aux_exp(2'h1, 1'h0));
    pas_sw_model_i.wr_reg(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    for (i = 0; i < 3; i = i + 1) begin
      pas_sw_model_i.set_page(pg[i]);
      rd(5'h1F, {11'h000, pg[i]});
      pas_sw_model_i.wr_reg(5'h1E, {11'h5A3, pg[i]});
    end
    for (i = 0; i < 3; i = i + 1) begin
      pas_sw_model_i.set_page(pg[i]);
      rd(5'h1E, {11'h5A3, pg[i]});
    end
    pas_sw_model_i.wr_reg(5'h1F, 16'hFFE1);
    rd(5'h1F, 16'h0001);
    pas_sw_model_i.wr_reg(5'h10, 16'h1234);
    rd(5'h10, 16'h0000);
    rd(5'h1C, 16'h0000);
    pas_sw_model_i.set_page(5'h03);
    rd(5'h1E, 16'h0000);
    pas_sw_model_i.set_page(5'h00);
    rd(5'h1C, aux_exp(2'h1, 1'h0));
    pas_sw_model_i.wr_reg(5'h1C, 16'h0040);
    n = 0;
    while (low_power_state !== 1'h1 && n < 40) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    chk("low power delay", 1'h1, n >= 9 && n <= 13);
    @(posedge clk_sys);
    energy_detect <= 1'h1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("energy event", 1'h1, link_state_change_event);
    chk("low power", 1'h0, low_power_state);
    @(posedge clk_sys);
    energy_detect <= 1'h0;
    link_status <= 1'h1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("link event", 1'h1, link_state_change_event);
    @(negedge clk_sys);
    chk("event width", 1'h0, link_state_change_event);
    pas_sw_model_i.wr_reg(5'h1C, 16'h0000);
    energy_detect <= 1'h1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("masked energy", 1'h0, link_state_change_event);
    repeat (3) @(posedge clk_sys);
    stop_test;
  end
endmodule
